/* adc_start_of_conversion_select_tb.sv */
// Self-checking bench for the conversion start selector
`timescale 1ns/1ps
`include "adcs_defines.svh"
module adc_start_of_conversion_select_tb;
    typedef struct {logic tm; logic [2:0] src; logic [1:0] kind; logic [1:0] idx; int starts; int lat;} adcs_row_type;
    // Kind: 0 busy write, 1 timer overflow, 2 pin rise
    adcs_row_type rows [15] = '{
        '{1'h0, 3'h0, 2'h0, 2'h0, 1, 0}, '{1'h0, 3'h1, 2'h1, 2'h0, 1, 2}, '{1'h0, 3'h2, 2'h1, 2'h2, 1, 2},
        '{1'h0, 3'h3, 2'h1, 2'h1, 1, 2}, '{1'h0, 3'h4, 2'h2, 2'h0, 1, 0}, '{1'h0, 3'h5, 2'h1, 2'h3, 1, 2},
        '{1'h0, 3'h1, 2'h1, 2'h1, 0, 0}, '{1'h0, 3'h6, 2'h1, 2'h0, 0, 0}, '{1'h0, 3'h7, 2'h0, 2'h0, 0, 0},
        '{1'h1, 3'h0, 2'h0, 2'h0, 1, 0}, '{1'h1, 3'h1, 2'h1, 2'h0, 1, 14}, '{1'h1, 3'h2, 2'h1, 2'h2, 1, 14},
        '{1'h1, 3'h3, 2'h1, 2'h1, 1, 14}, '{1'h1, 3'h4, 2'h2, 2'h0, 1, 0}, '{1'h1, 3'h5, 2'h1, 2'h3, 1, 14}};
    logic ref_clk = 1'h0;
    logic nrst = 1'h0;
    logic fire = 1'h0;
    logic [1:0] fire_idx = 2'h0;
    logic pin_req = 1'h0;
    logic slow = 1'h0;
    logic timer0_overflow, timer1_overflow, timer2_overflow, timer3_overflow;
    logic external_convert_start_pin, conversion_done, track_enable, conversion_start, conversion_busy;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, b_resp, rr;
    logic [31:0] s_axi_rdata, rd;
    int n_errors = 0;
    int check_count = 0;
    int starts_seen = 0;
    int s0;
    int n;
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (conversion_start === 1'h1) starts_seen <= starts_seen + 1;
    adcs_top u_adcs_top (.ref_clk(ref_clk), .nrst(nrst), .timer0_overflow(timer0_overflow),
        .timer1_overflow(timer1_overflow), .timer2_overflow(timer2_overflow), .timer3_overflow(timer3_overflow),
        .external_convert_start_pin(external_convert_start_pin), .conversion_done(conversion_done),
        .track_enable(track_enable), .conversion_start(conversion_start), .conversion_busy(conversion_busy),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    adcs_far_model u_adcs_far_model (.ref_clk(ref_clk), .fire(fire), .fire_idx(fire_idx), .pin_req(pin_req),
        .slow(slow), .conversion_start(conversion_start), .timer0_overflow(timer0_overflow),
        .timer1_overflow(timer1_overflow), .timer2_overflow(timer2_overflow), .timer3_overflow(timer3_overflow),
        .external_convert_start_pin(external_convert_start_pin), .conversion_done(conversion_done));
    // ****************************************
    // Tasks
    // ****************************************
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task timeout(input string what);
        n_errors++;
        $display("mismatch %s expected done seen timeout", what);
        results();
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready) break;
        end
        if (n == 40) timeout("write");
        b_resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_read(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && s_axi_rready) break;
        end
        if (n == 40) timeout("read");
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic fire_timer(input logic [1:0] i);
        @(posedge ref_clk);
        fire <= 1'h1;
        fire_idx <= i;
        @(posedge ref_clk);
        fire <= 1'h0;
    endtask
    task automatic wait_idle;
        repeat (20) @(posedge ref_clk);
        for (n = 0; n < 80 && conversion_busy !== 1'h0; n++) @(posedge ref_clk);
        if (n == 80) timeout("idle");
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'h1;
        repeat (4) @(posedge ref_clk);
        axi_read(`ADCS_CTRL_OFFSET);
        check("ctrl reset", rd, `ADCS_CTRL_RESET);
        foreach (rows[i]) begin
            slow <= i[0];
            axi_write(`ADCS_CTRL_OFFSET, {28'h0, rows[i].tm, rows[i].src});
            repeat (6) @(posedge ref_clk);
            if (rows[i].kind == 2'h2 && rows[i].tm) check("track low pin", {31'h0, track_enable}, 32'h1);
            s0 = starts_seen;
            if (rows[i].kind == 2'h0) axi_write(`ADCS_CTRL_OFFSET, {27'h1, rows[i].tm, rows[i].src});
            else if (rows[i].kind == 2'h1) fire_timer(rows[i].idx);
            else pin_req <= 1'h1;
            if (rows[i].lat != 0) begin
                for (n = 0; n < 30 && conversion_start !== 1'h1; n++) @(posedge ref_clk);
                check("start latency", n, rows[i].lat);
            end
            wait_idle();
            check("starts", starts_seen - s0, rows[i].starts);
            pin_req <= 1'h0;
            // Let the pin fall settle under the old source before the next one is written
            repeat (6) @(posedge ref_clk);
        end
        // Overflow mid-conversion is dropped; the next one after idle is taken
        slow <= 1'h1;
        axi_write(`ADCS_CTRL_OFFSET, {29'h0, `ADCS_SRC_TMR0});
        s0 = starts_seen;
        fire_timer(2'h0);
        repeat (3) @(posedge ref_clk);
        fire_timer(2'h0);
        wait_idle();
        fire_timer(2'h0);
        wait_idle();
        check("dropped trigger", starts_seen - s0, 2);
        axi_read(`ADCS_COUNT_OFFSET);
        check("start count", {16'h0, rd[15:0]}, {16'h0, starts_seen[15:0]});
        // Reserved code aborts pin-driven tracking
        axi_write(`ADCS_CTRL_OFFSET, {28'h1, `ADCS_SRC_PIN});
        repeat (6) @(posedge ref_clk);
        s0 = starts_seen;
        axi_write(`ADCS_CTRL_OFFSET, 32'he);
        repeat (3) @(posedge ref_clk);
        check("abort track", {31'h0, track_enable}, 32'h0);
        pin_req <= 1'h1;
        repeat (20) @(posedge ref_clk);
        check("reserved start", starts_seen - s0, 0);
        axi_read(8'h0c);
        check("unmapped read", {rr, rd[29:0]}, {`ADCS_RESP_DECERR, 30'h0});
        axi_write(8'h0c, 32'h1);
        check("unmapped write", {30'h0, b_resp}, {30'h0, `ADCS_RESP_DECERR});
        results();
    end
endmodule // adc_start_of_conversion_select_tb
bind adcs_top adcs_top_sva u_adcs_top_sva (.ref_clk(ref_clk), .nrst(nrst), .timer0_overflow(timer0_overflow),
    .timer1_overflow(timer1_overflow), .timer2_overflow(timer2_overflow), .timer3_overflow(timer3_overflow),
    .external_convert_start_pin(external_convert_start_pin), .conversion_done(conversion_done),
    .track_enable(track_enable), .conversion_start(conversion_start), .conversion_busy(conversion_busy),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready));

/* adcs_defines.svh */
// Offsets, field positions, reset values and timing counts for the conversion start selector
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ADCS_CTRL_OFFSET 8'h00
`define ADCS_STATUS_OFFSET 8'h04
`define ADCS_COUNT_OFFSET 8'h08

// ****************************************
// Control register fields
// ****************************************
`define ADCS_SRC_LSB 0
`define ADCS_SRC_MSB 2
`define ADCS_TM_BIT 3
`define ADCS_BUSY_BIT 4
`define ADCS_CTRL_RESET 32'h0000_0000

// ****************************************
// Start source codes
// ****************************************
`define ADCS_SRC_SOFT 3'h0
`define ADCS_SRC_TMR0 3'h1
`define ADCS_SRC_TMR2 3'h2
`define ADCS_SRC_TMR1 3'h3
`define ADCS_SRC_PIN 3'h4
`define ADCS_SRC_TMR3 3'h5

// ****************************************
// Timing
// ****************************************
// SAR clock is ref_clk divided by four; last divider count below
`define ADCS_SAR_DIV_LAST 8'h03
// Tracking lasts three SAR clocks; last tracking count below
`define ADCS_TRACK_LAST 2'h2

// ****************************************
// Bus answers
// ****************************************
`define ADCS_RESP_OKAY 2'h0
`define ADCS_RESP_DECERR 2'h3

`endif

/* adcs_far_model.sv */
// Timers, convert-start pin and converter datapath around the selector
`timescale 1ns/1ps
module adcs_far_model (
    input wire logic ref_clk,
    input wire logic fire,
    input wire logic [1:0] fire_idx,
    input wire logic pin_req,
    input wire logic slow,
    input wire logic conversion_start,
    output logic timer0_overflow,
    output logic timer1_overflow,
    output logic timer2_overflow,
    output logic timer3_overflow,
    output logic external_convert_start_pin,
    output logic conversion_done
);
    logic run = 1'h0;
    logic [3:0] cnt = 4'h0;
    initial begin
        {timer0_overflow, timer1_overflow, timer2_overflow, timer3_overflow} = 4'h0;
        external_convert_start_pin = 1'h0;
        conversion_done = 1'h0;
    end
    always @(posedge ref_clk) begin
        timer0_overflow <= fire && fire_idx == 2'h0;
        timer1_overflow <= fire && fire_idx == 2'h1;
        timer2_overflow <= fire && fire_idx == 2'h2;
        timer3_overflow <= fire && fire_idx == 2'h3;
        external_convert_start_pin <= pin_req;
        conversion_done <= 1'h0;
        // Slow converter leaves a window for triggers to be dropped
        if (conversion_start) begin
            run <= 1'h1;
            cnt <= slow ? 4'h9 : 4'h1;
        end else if (run && cnt == 4'h0) begin
            run <= 1'h0;
            conversion_done <= 1'h1;
        end else if (run) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule // adcs_far_model

/* adcs_pkg.sv */
// Types for the conversion start selector
package adcs_pkg;

    typedef enum logic [1:0] {
        ADCS_IDLE,
        ADCS_TRACK,
        ADCS_CONVERT
    } adcs_fsm_type;

    typedef struct packed {
        adcs_fsm_type fsm;
        logic [2:0] src;
        logic tm;
        logic busy;
        logic track;
        logic conv_start;
        logic pin_prev;
        logic [7:0] div_cnt;
        logic [1:0] trk_cnt;
        logic [15:0] conv_count;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic wlane0;
    } adcs_state_type;

endpackage

/* adcs_sync.sv */
// Two flip-flop synchroniser, also used to release the reset
`timescale 1ns/1ps

module adcs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } adcs_sync_state_type;

    adcs_sync_state_type st;
    adcs_sync_state_type next_st;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;
        // First stage feeds only the second stage
        next_st.meta = d;
        next_st.q = st.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;

endmodule // adcs_sync

/* adcs_top.sv */
// Start-of-conversion source selection and tracking sequencer with AXI4-Lite registers
// Summary of operation
// (R1) Normal mode, source 000: software writing one to busy starts conversion.
// (R2) Normal mode, source 001: each timer 0 overflow starts conversion.
// (R3) Normal mode, source 010: each timer 2 overflow starts conversion.
// (R4) Normal mode, source 011: each timer 1 overflow starts conversion.
// (R5) Normal mode, source 100: rising edge of convert-start pin starts conversion.
// (R6) Normal mode, source 101: timer 3 overflow starts conversion; 11x reserved.
// (R7) Delayed mode, source 000: busy write tracks three SAR clocks, then converts.
// (R8) Delayed mode, source 001: timer 0 overflow tracks three SAR clocks, then converts.
// (R9) Delayed mode, source 010: timer 2 overflow tracks three SAR clocks, then converts.
// (R10) Delayed mode, source 011: timer 1 overflow tracks three SAR clocks, then converts.
// (R11) Delayed mode, source 100: track while pin low, convert on its rising edge.
// (R12) Delayed mode, source 101: timer 3 overflow tracks three SAR clocks, then converts.
// (R13) Reserved source codes ignore every trigger; nothing tracks or converts.
`timescale 1ns/1ps
`include "adcs_defines.svh"

module adcs_top (
    input wire logic ref_clk,
    input wire logic nrst,
    // Trigger sources
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer2_overflow,
    input wire logic timer3_overflow,
    input wire logic external_convert_start_pin,
    // Converter datapath
    input wire logic conversion_done,
    output logic track_enable,
    output logic conversion_start,
    output logic conversion_busy,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ****************************************
    // Reset release and pin synchronisation
    // ****************************************
    logic rst_n;
    logic pin_sync;

    adcs_sync #(
        .W(1)
    ) u_rst_sync (
        .clk(ref_clk),
        .rst_n(nrst),
        .d(1'b1),
        .q(rst_n)
    );

    // Pin is asynchronous to ref_clk, so it is read only after two flops
    adcs_sync #(
        .W(1)
    ) u_pin_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .d(external_convert_start_pin),
        .q(pin_sync)
    );

    // ****************************************
    // State
    // ****************************************
    adcs_pkg::adcs_state_type st;
    adcs_pkg::adcs_state_type next_st;

    logic sw_start;
    logic trig;
    logic pin_rise;
    logic sar_tick;
    logic reserved_src;
    logic pin_mode;
    logic wr_fire;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    always_comb begin
        next_st = st;
        sw_start = 1'b0;
        trig = 1'b0;
        rd_word = 32'h0000_0000;
        rd_resp = `ADCS_RESP_OKAY;
        next_st.conv_start = 1'b0;

        // ****************************************
        // Write channels
        // ****************************************
        // Address and data are taken in either order and held until both are in
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wlane0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        wr_fire = next_st.aw_got && next_st.w_got && !next_st.bvalid;
        if (wr_fire) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `ADCS_RESP_OKAY;
            if (next_st.awaddr == `ADCS_CTRL_OFFSET) begin
                // Only the low byte holds fields; other lanes are ignored
                if (next_st.wlane0) begin
                    next_st.src = next_st.wdata[`ADCS_SRC_MSB:`ADCS_SRC_LSB];
                    next_st.tm = next_st.wdata[`ADCS_TM_BIT];
                    // Writing zero to busy never aborts a conversion
                    sw_start = next_st.wdata[`ADCS_BUSY_BIT];
                end
            end else if (next_st.awaddr == `ADCS_STATUS_OFFSET) begin
                next_st.bresp = `ADCS_RESP_OKAY;
            end else if (next_st.awaddr == `ADCS_COUNT_OFFSET) begin
                next_st.bresp = `ADCS_RESP_OKAY;
            end else begin
                next_st.bresp = `ADCS_RESP_DECERR;
            end
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;

        // ****************************************
        // Read channel
        // ****************************************
        if (s_axi_araddr == `ADCS_CTRL_OFFSET) begin
            rd_word = {27'h0000000, st.busy, st.tm, st.src};
        end else if (s_axi_araddr == `ADCS_STATUS_OFFSET) begin
            rd_word = {29'h00000000, st.track, 2'(st.fsm)};
        end else if (s_axi_araddr == `ADCS_COUNT_OFFSET) begin
            rd_word = {16'h0000, st.conv_count};
        end else begin
            rd_resp = `ADCS_RESP_DECERR;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_word;
            next_st.rresp = rd_resp;
        end
        next_st.arready = !next_st.rvalid;

        // ****************************************
        // SAR clock divider and pin edge
        // ****************************************
        sar_tick = (st.div_cnt == `ADCS_SAR_DIV_LAST);
        next_st.div_cnt = sar_tick ? 8'h00 : 8'(st.div_cnt + 8'h01);
        next_st.pin_prev = pin_sync;
        pin_rise = pin_sync && !st.pin_prev;

        // ****************************************
        // Trigger selection
        // ****************************************
        // The freshly written source applies to a start written in the same access
        reserved_src = 1'b0;
        case (next_st.src)
            `ADCS_SRC_SOFT: begin
                trig = sw_start; // [R1] [R7]
            end
            `ADCS_SRC_TMR0: begin
                trig = timer0_overflow; // [R2] [R8]
            end
            `ADCS_SRC_TMR2: begin
                trig = timer2_overflow; // [R3] [R9]
            end
            `ADCS_SRC_TMR1: begin
                trig = timer1_overflow; // [R4] [R10]
            end
            `ADCS_SRC_PIN: begin
                trig = pin_rise; // [R5] [R11]
            end
            `ADCS_SRC_TMR3: begin
                trig = timer3_overflow; // [R6] [R12]
            end
            default: begin
                // Reserved codes start nothing
                trig = 1'b0; // [R6] [R13]
                reserved_src = 1'b1;
            end
        endcase
        pin_mode = next_st.tm && (next_st.src == `ADCS_SRC_PIN);

        // ****************************************
        // Sequencer
        // ****************************************
        // Triggers arriving while tracking or converting are dropped, as the
        // converter can hold only one conversion at a time
        case (st.fsm)
            adcs_pkg::ADCS_IDLE: begin
                if (trig) begin
                    next_st.busy = 1'b1;
                    if (next_st.tm && !pin_mode) begin
                        // Restart the divider so tracking is exactly three SAR clocks
                        next_st.fsm = adcs_pkg::ADCS_TRACK; // [R7] [R8] [R9] [R10] [R12]
                        next_st.div_cnt = 8'h00;
                        next_st.trk_cnt = 2'h0;
                    end else begin
                        next_st.fsm = adcs_pkg::ADCS_CONVERT; // [R1] [R2] [R3] [R4] [R5] [R6] [R11]
                        next_st.conv_start = 1'b1;
                        next_st.conv_count = 16'(st.conv_count + 16'h0001);
                    end
                end
            end
            adcs_pkg::ADCS_TRACK: begin
                if (reserved_src) begin
                    // Switching to a reserved code abandons the tracking phase
                    next_st.fsm = adcs_pkg::ADCS_IDLE; // [R13]
                    next_st.busy = 1'b0;
                end else if (sar_tick) begin
                    next_st.trk_cnt = 2'(st.trk_cnt + 2'h1);
                    if (st.trk_cnt == `ADCS_TRACK_LAST) begin
                        next_st.fsm = adcs_pkg::ADCS_CONVERT; // [R7] [R8] [R9] [R10] [R12]
                        next_st.conv_start = 1'b1;
                        next_st.conv_count = 16'(st.conv_count + 16'h0001);
                    end
                end
            end
            adcs_pkg::ADCS_CONVERT: begin
                if (conversion_done) begin
                    next_st.fsm = adcs_pkg::ADCS_IDLE;
                    next_st.busy = 1'b0;
                end
            end
            default: begin
                next_st.fsm = adcs_pkg::ADCS_IDLE;
            end
        endcase

        // ****************************************
        // Track output
        // ****************************************
        if (next_st.fsm == adcs_pkg::ADCS_TRACK) begin
            next_st.track = 1'b1; // [R7] [R8] [R9] [R10] [R12]
        end else if (next_st.fsm == adcs_pkg::ADCS_CONVERT || reserved_src) begin
            next_st.track = 1'b0; // [R13]
        end else if (pin_mode) begin
            next_st.track = !pin_sync; // [R11]
        end else begin
            // Normal mode tracks whenever idle; delayed mode rests until a trigger
            next_st.track = !next_st.tm;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign track_enable = st.track;
    assign conversion_start = st.conv_start;
    assign conversion_busy = st.busy;
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bresp = st.bresp;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_arready = st.arready;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rvalid = st.rvalid;

endmodule // adcs_top

/* adcs_top_sva.sv */
// Concurrent checks on the conversion start selector ports
`timescale 1ns/1ps
`include "adcs_defines.svh"
module adcs_top_sva (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer2_overflow,
    input wire logic timer3_overflow,
    input wire logic external_convert_start_pin,
    input wire logic conversion_done,
    input wire logic track_enable,
    input wire logic conversion_start,
    input wire logic conversion_busy,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready
);
    logic [2:0] src;
    logic tm;
    logic wr;
    logic sw;
    logic hit;
    logic pin_mode;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ****************************************
    // Control shadow, only exact when address and data arrive together
    // ****************************************
    assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
        && s_axi_awaddr == `ADCS_CTRL_OFFSET;
    assign sw = wr && s_axi_wdata[`ADCS_BUSY_BIT] && s_axi_wdata[2:0] == `ADCS_SRC_SOFT && !conversion_busy;
    assign hit = !conversion_busy && (src == `ADCS_SRC_TMR0 && timer0_overflow || src == `ADCS_SRC_TMR1 && timer1_overflow
        || src == `ADCS_SRC_TMR2 && timer2_overflow || src == `ADCS_SRC_TMR3 && timer3_overflow);
    assign pin_mode = src == `ADCS_SRC_PIN && !conversion_busy;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            src <= 3'h0;
            tm <= 1'h0;
        end else if (wr) begin
            src <= s_axi_wdata[2:0];
            tm <= s_axi_wdata[`ADCS_TM_BIT];
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    norm_timer_a: assert property (!tm && hit |=> conversion_start && conversion_busy)
        else $error("timer overflow did not start a conversion");
    delay_timer_a: assert property (tm && hit |=> (track_enable && !conversion_start)[*8] ##5 conversion_start)
        else $error("timer tracking phase is not three SAR clocks");
    sw_norm_a: assert property (sw && !s_axi_wdata[`ADCS_TM_BIT] |=> conversion_start)
        else $error("busy write did not start a conversion");
    sw_delay_a: assert property (sw && s_axi_wdata[`ADCS_TM_BIT] |=> track_enable[*8] ##5 conversion_start)
        else $error("busy write tracking phase wrong");
    pin_start_a: assert property (!tm && pin_mode && $rose(external_convert_start_pin) |-> ##[2:5] conversion_start)
        else $error("pin rise did not start a conversion");
    pin_track_a: assert property (tm && pin_mode && $fell(external_convert_start_pin) |-> ##[1:4] track_enable)
        else $error("low pin did not start tracking");
    reserved_quiet_a: assert property (src[2:1] == 2'h3 && $past(src[2:1]) == 2'h3 |-> !track_enable && !conversion_start)
        else $error("reserved source still active");
    busy_end_a: assert property (conversion_done && conversion_busy |=> !conversion_busy)
        else $error("busy did not fall after done");
    start_shape_a: assert property (conversion_start |-> !track_enable ##1 !conversion_start)
        else $error("start pulse malformed");
    cover property (tm && conversion_start);
    cover property (src[2:1] == 2'h3 && wr);
    cover property (pin_mode && $rose(external_convert_start_pin));
endmodule // adcs_top_sva
